// ---- design/aux3_pkg.sv ----
package aux3_pkg;

    // register offsets on the documented register port
    localparam logic [7:0] POWER_GOOD_MASK_A_OFFSET  = 8'h1f;
    localparam logic [7:0] SOURCE_SELECT_OFFSET = 8'h20;
    localparam logic [7:0] EDGE_TIMING_OFFSET   = 8'h21;

    // value held before the configuration memory is copied in
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    // field positions
    localparam int SRC_OPTION_BIT  = 7;
    localparam int SRC_FIELD_LSB   = 2;
    localparam int SRC_MASK_SWB2   = 1;
    localparam int SRC_MASK_LOAD_SWITCH_B_FIRST   = 0;
    localparam int TIM_COMBINE_BIT = 7;
    localparam int TIM_SWAP_BIT    = 6;
    localparam int TIM_FALL_LSB    = 3;
    localparam int TIM_RISE_LSB    = 0;
    localparam int FIELD3_WIDTH    = 3;

    // timing: delays count in whole milliseconds
    localparam int CLOCK_MHZ     = 250;
    localparam int DELAY_UNIT_US = 1000;
    localparam int TICK_CYCLES   = DELAY_UNIT_US * CLOCK_MHZ;

    // delay figures in milliseconds
    localparam logic [6:0] DLY_0_MS  = 7'h00;
    localparam logic [6:0] DLY_2_MS  = 7'h02;
    localparam logic [6:0] DLY_4_MS  = 7'h04;
    localparam logic [6:0] DLY_8_MS  = 7'h08;
    localparam logic [6:0] DLY_16_MS = 7'h10;
    localparam logic [6:0] DLY_24_MS = 7'h18;
    localparam logic [6:0] DLY_32_MS = 7'h20;
    localparam logic [6:0] DLY_64_MS = 7'h40;

    // enable source selector codes
    typedef enum logic [2:0] {
        SRC_CONTROL_INPUT_1      = 3'b000,
        SRC_CONTROL_INPUT_2      = 3'b001,
        SRC_CONTROL_INPUT_5      = 3'b010,
        SRC_CONTROL_INPUT_4      = 3'b011,
        SRC_CONTROL_INPUT_3      = 3'b100,
        SRC_CONTROL_INPUT_3_CONTROL_INPUT_4 = 3'b101,
        SRC_CONTROL_INPUT_6      = 3'b110,
        SRC_ALWAYS    = 3'b111
    } source_e;

    // power-good terms, same order as {mask_a, source_select[1:0]}
    typedef struct packed {
        logic       aux2;
        logic       load_a;
        logic [5:0] rail;      // rail[5] is step-down rail 6
        logic       swb2_reg1;
        logic       load_switch_b_first;
    } power_good_s;

    // control pins, ctl[0] is control input 1
    typedef struct packed {
        logic       sleep;
        logic [5:0] ctl;
    } pins_s;

    localparam int POWER_GOOD_WIDTH = $bits(power_good_s);
    localparam int PINS_WIDTH  = $bits(pins_s);

    // delay code to milliseconds
    function automatic logic [6:0] delay_ms(input logic [2:0] code);
        unique case (code)
            3'h0: delay_ms = DLY_0_MS;
            3'h1: delay_ms = DLY_2_MS;
            3'h2: delay_ms = DLY_4_MS;
            3'h3: delay_ms = DLY_8_MS;
            3'h4: delay_ms = DLY_16_MS;
            3'h5: delay_ms = DLY_24_MS;
            3'h6: delay_ms = DLY_32_MS;
            3'h7: delay_ms = DLY_64_MS;
        endcase
    endfunction

endpackage

// ---- design/edge_delay_timer.sv ----
`timescale 1ns/1ns
module edge_delay_timer #(
    parameter int TICK_CYCLES = aux3_pkg::TICK_CYCLES
) (
    input  wire logic       clk_in,       // system clock
    input  wire logic       rstn_in,      // synchronous reset, low
    input  wire logic       level_in,     // undelayed enable
    input  wire logic [2:0] rise_code_in, // rising edge delay code
    input  wire logic [2:0] fall_code_in, // falling edge delay code
    output logic            level_out     // delayed enable
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    typedef enum logic {
        ST_STEADY  = 1'b0,
        ST_PENDING = 1'b1
    } timer_state_e;

    timer_state_e  state_reg;
    logic [TW-1:0] tick_reg;
    logic [6:0]    ms_reg;
    logic [6:0]    delay_now;

    // delay that applies to the edge now waiting
    assign delay_now = level_in ? aux3_pkg::delay_ms(rise_code_in)
                                : aux3_pkg::delay_ms(fall_code_in);

    // follow the input once it has held for the whole delay
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            state_reg <= ST_STEADY;
            tick_reg  <= '0;
            ms_reg    <= 7'h00;
            level_out <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_STEADY:
                begin
                    tick_reg <= '0;
                    ms_reg   <= 7'h00;
                    if (level_in != level_out)
                    begin
                        if (delay_now == aux3_pkg::DLY_0_MS)
                            level_out <= level_in;
                        else
                            state_reg <= ST_PENDING;
                    end
                end
                ST_PENDING:
                begin
                    if (level_in == level_out)
                        state_reg <= ST_STEADY;            // edge withdrawn
                    else if (tick_reg == TICK_LAST)
                    begin
                        tick_reg <= '0;
                        if (ms_reg + 7'h01 >= delay_now)
                        begin
                            level_out <= level_in;
                            state_reg <= ST_STEADY;
                        end
                        else
                            ms_reg <= ms_reg + 7'h01;
                    end
                    else
                        tick_reg <= tick_reg + TW'(1);
                end
            endcase
        end
    end

endmodule // edge_delay_timer

// ---- design/aux_rail3_enable_logic.sv ----
// Function
// - mask bit 0 keeps that rail's power-good in the enable, 1 drops it.
// - first register masks aux regulator 2, load switch A, rails 6..1.
// - second register bit 1 masks switch B2/reg 1, bit 0 switch B1.
// - source field bits 4:2 pick control 1,2,5,4,3, 3-and-4 or 6.
// - source code 111 feeds a constant one, no pin needed.
// - option bit set lets control 2 high preset rail 6 to 1.2/2.4 V.
// - sleep input overrides the control 2 preset on rail 6.
// - rise and fall delay fields delay enable edges 0 to 64 ms.
// - combine bit drives switch B2 from switch B1's enable logic.
// - swap bit feeds reg 1 from switch B2's logic, and switch B2 from reg 1's unless combine is set.
`timescale 1ns/1ns
module aux_rail3_enable_logic #(
    parameter int TICK_CYCLES = aux3_pkg::TICK_CYCLES
) (
    input  wire logic            CLOCK_IN,          // 250 MHz clock
    input  wire logic            RSTN_IN,           // sync reset, low
    input  wire aux3_pkg::power_good_s POWER_GOOD_IN,    // other rails' good
    input  wire aux3_pkg::pins_s CONTROL_PINS_IN,   // control and sleep
    input  wire logic            RAIL6_STEP_25MV_IN, // rail 6 step 25 mV
    input  wire logic            LOAD_SWITCH_B_FIRST_LOGIC_IN,     // switch B1 enable
    input  wire logic            SWB2_LOGIC_IN,     // switch B2 enable
    input  wire logic            REG1_LOGIC_IN,     // regulator 1 enable
    input  wire logic [7:0]      OTP_MASK_A_IN,     // stored default
    input  wire logic [7:0]      OTP_SOURCE_IN,     // stored default
    input  wire logic [7:0]      OTP_TIMING_IN,     // stored default
    input  wire logic [7:0]      REG_ADDR_IN,       // register offset
    input  wire logic            REG_WR_IN,         // write strobe
    input  wire logic [7:0]      REG_WDATA_IN,      // write data
    output logic [7:0]           REG_RDATA_OUT,     // read data
    output logic                 CONFIG_READY_OUT,  // defaults loaded
    output logic                 AUX3_ENABLE_OUT,   // delayed enable
    output logic                 RAIL6_PRESET_OUT,  // preset requested
    output logic                 RAIL6_PRESET_2V4_OUT, // preset is 2.4 V
    output logic                 SWB2_ENABLE_OUT,   // switch B2 enable
    output logic                 REG1_ENABLE_OUT    // regulator 1 enable
);
    localparam int PW = aux3_pkg::PINS_WIDTH;
    localparam int GW = aux3_pkg::POWER_GOOD_WIDTH;
    localparam int AW = PW + GW;

    logic [7:0]      mask_a_reg;
    logic [7:0]      source_reg;
    logic [7:0]      timing_reg;
    logic            loaded_reg;
    logic [AW-1:0]   sync1_reg;
    logic [AW-1:0]   sync2_reg;
    logic [AW-1:0]   sync3_reg;
    logic [AW-1:0]   clean_reg;
    logic [AW-1:0]   pin_vec;
    aux3_pkg::pins_s  pins;
    aux3_pkg::power_good_s good;
    logic [GW-1:0]   mask_vec;
    logic            good_term;
    logic            pin_term;
    logic            raw_enable_reg;
    logic            raw_enable_next;
    logic [2:0]      src_field;
    logic            preset_next;
    logic            reg1_next;
    logic            swb2_next;

    // configuration: copied from memory once, then software writes
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RSTN_IN)
        begin
            mask_a_reg <= aux3_pkg::REG_RESET_VALUE;
            source_reg <= aux3_pkg::REG_RESET_VALUE;
            timing_reg <= aux3_pkg::REG_RESET_VALUE;
            loaded_reg <= 1'b0;
        end
        else if (!loaded_reg)
        begin
            mask_a_reg <= OTP_MASK_A_IN;
            source_reg <= OTP_SOURCE_IN;
            timing_reg <= OTP_TIMING_IN;
            loaded_reg <= 1'b1;
        end
        else if (REG_WR_IN)
        begin
            if (REG_ADDR_IN == aux3_pkg::POWER_GOOD_MASK_A_OFFSET)
                mask_a_reg <= REG_WDATA_IN;
            if (REG_ADDR_IN == aux3_pkg::SOURCE_SELECT_OFFSET)
                source_reg <= REG_WDATA_IN;
            if (REG_ADDR_IN == aux3_pkg::EDGE_TIMING_OFFSET)
                timing_reg <= REG_WDATA_IN;
        end
    end

    // read data, unmapped offsets read zero
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RSTN_IN)
            REG_RDATA_OUT <= 8'h00;
        else if (REG_ADDR_IN == aux3_pkg::POWER_GOOD_MASK_A_OFFSET)
            REG_RDATA_OUT <= mask_a_reg;
        else if (REG_ADDR_IN == aux3_pkg::SOURCE_SELECT_OFFSET)
            REG_RDATA_OUT <= source_reg;
        else if (REG_ADDR_IN == aux3_pkg::EDGE_TIMING_OFFSET)
            REG_RDATA_OUT <= timing_reg;
        else
            REG_RDATA_OUT <= 8'h00;
    end

    // raw pin levels, power-good in the low bits
    assign pin_vec = {CONTROL_PINS_IN, POWER_GOOD_IN};

    // three-stage synchroniser per pin, accept when stages 2 and 3 agree
    genvar i;
    generate
        for (i = 0; i < AW; i++)
        begin : g_sync
            always_ff @(posedge CLOCK_IN)
            begin
                if (!RSTN_IN)
                begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                    sync3_reg[i] <= 1'b0;
                    clean_reg[i] <= 1'b0;
                end
                else
                begin
                    sync1_reg[i] <= pin_vec[i];
                    sync2_reg[i] <= sync1_reg[i];
                    sync3_reg[i] <= sync2_reg[i];
                    if (sync2_reg[i] == sync3_reg[i])
                        clean_reg[i] <= sync3_reg[i];
                end
            end
        end
    endgenerate

    assign good = aux3_pkg::power_good_s'(clean_reg[GW-1:0]);
    assign pins = aux3_pkg::pins_s'(clean_reg[AW-1:GW]);

    // masks lined up with the power-good struct
    assign mask_vec = {mask_a_reg,
                       source_reg[aux3_pkg::SRC_MASK_SWB2],
                       source_reg[aux3_pkg::SRC_MASK_LOAD_SWITCH_B_FIRST]};

    // a masked rail counts as good
    assign good_term = &(GW'(good) | mask_vec);

    assign src_field = source_reg[aux3_pkg::SRC_FIELD_LSB +:
                                  aux3_pkg::FIELD3_WIDTH];

    // control input selector
    always_comb
    begin
        unique case (aux3_pkg::source_e'(src_field))
            aux3_pkg::SRC_CONTROL_INPUT_1:      pin_term = pins.ctl[0];
            aux3_pkg::SRC_CONTROL_INPUT_2:      pin_term = pins.ctl[1];
            aux3_pkg::SRC_CONTROL_INPUT_5:      pin_term = pins.ctl[4];
            aux3_pkg::SRC_CONTROL_INPUT_4:      pin_term = pins.ctl[3];
            aux3_pkg::SRC_CONTROL_INPUT_3:      pin_term = pins.ctl[2];
            aux3_pkg::SRC_CONTROL_INPUT_3_CONTROL_INPUT_4: pin_term = pins.ctl[2]
                                              & pins.ctl[3];
            aux3_pkg::SRC_CONTROL_INPUT_6:      pin_term = pins.ctl[5];
            aux3_pkg::SRC_ALWAYS:    pin_term = 1'b1;
        endcase
    end

    assign raw_enable_next = loaded_reg & pin_term & good_term;

    // undelayed enable
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RSTN_IN)
            raw_enable_reg <= 1'b0;
        else
            raw_enable_reg <= raw_enable_next;
    end

    // edge delays on the rail enable
    edge_delay_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_delay (
        .clk_in       (CLOCK_IN),
        .rstn_in      (RSTN_IN),
        .level_in     (raw_enable_reg),
        .rise_code_in (timing_reg[aux3_pkg::TIM_RISE_LSB +:
                                  aux3_pkg::FIELD3_WIDTH]),
        .fall_code_in (timing_reg[aux3_pkg::TIM_FALL_LSB +:
                                  aux3_pkg::FIELD3_WIDTH]),
        .level_out    (AUX3_ENABLE_OUT)
    );

    // rail 6 preset voltage request, sleep wins
    assign preset_next = source_reg[aux3_pkg::SRC_OPTION_BIT]
                       & pins.ctl[1]
                       & ~pins.sleep;

    always_ff @(posedge CLOCK_IN)
    begin
        if (!RSTN_IN)
        begin
            RAIL6_PRESET_OUT     <= 1'b0;
            RAIL6_PRESET_2V4_OUT <= 1'b0;
        end
        else
        begin
            RAIL6_PRESET_OUT     <= preset_next;
            RAIL6_PRESET_2V4_OUT <= preset_next & RAIL6_STEP_25MV_IN;
        end
    end

    // switch B2 and regulator 1 enable routing
    assign reg1_next = timing_reg[aux3_pkg::TIM_SWAP_BIT]
                     ? SWB2_LOGIC_IN : REG1_LOGIC_IN;
    assign swb2_next = timing_reg[aux3_pkg::TIM_COMBINE_BIT]
                     ? LOAD_SWITCH_B_FIRST_LOGIC_IN
                     : (timing_reg[aux3_pkg::TIM_SWAP_BIT]
                        ? REG1_LOGIC_IN : SWB2_LOGIC_IN);

    always_ff @(posedge CLOCK_IN)
    begin
        if (!RSTN_IN)
        begin
            SWB2_ENABLE_OUT <= 1'b0;
            REG1_ENABLE_OUT <= 1'b0;
        end
        else
        begin
            SWB2_ENABLE_OUT <= loaded_reg & swb2_next;
            REG1_ENABLE_OUT <= loaded_reg & reg1_next;
        end
    end

    // configuration ready flag
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RSTN_IN)
            CONFIG_READY_OUT <= 1'b0;
        else
            CONFIG_READY_OUT <= loaded_reg;
    end

endmodule // aux_rail3_enable_logic

// ---- verification/rail_partner.sv ----
`timescale 1ns/1ns
// far side: other rails' power-good, control pins, rails' own logic
module rail_partner (
    input  wire logic        clk_in,   // system clock
    output aux3_pkg::power_good_s good_out, // rails' power-good
    output aux3_pkg::pins_s  pins_out, // sleep and control pins
    output logic [2:0]       logic_out // load_switch_b_first, swb2, reg1 logic
);
    // levels move just after a rising edge and then hold
    task automatic set_good(input aux3_pkg::power_good_s g);
        @(posedge clk_in);
        good_out <= g;
    endtask
    task automatic set_pins(input aux3_pkg::pins_s p);
        @(posedge clk_in);
        pins_out <= p;
    endtask
    task automatic set_logic(input logic [2:0] l);
        @(posedge clk_in);
        logic_out <= l;
    endtask

    // rails good and pins idle at power-up
    initial
    begin
        good_out = '1;
        pins_out = '0;
        logic_out = '0;
    end
endmodule // rail_partner

// ---- verification/aux_rail3_enable_logic_asserts.sv ----
`timescale 1ns/1ns
module aux_rail3_enable_logic_asserts (
    input wire logic            CLOCK_IN,         // clock
    input wire logic            RSTN_IN,          // reset, low
    input wire aux3_pkg::pins_s CONTROL_PINS_IN,  // pins
    input wire logic            LOAD_SWITCH_B_FIRST_LOGIC_IN,    // b1 logic
    input wire logic            SWB2_LOGIC_IN,    // b2 logic
    input wire logic            REG1_LOGIC_IN,    // reg 1 logic
    input wire logic            RAIL6_STEP_25MV_IN, // 25 mV step
    input wire logic [7:0]      OTP_MASK_A_IN,    // default
    input wire logic [7:0]      OTP_SOURCE_IN,    // default
    input wire logic [7:0]      OTP_TIMING_IN,    // default
    input wire logic [7:0]      REG_ADDR_IN,      // offset
    input wire logic            REG_WR_IN,        // strobe
    input wire logic [7:0]      REG_WDATA_IN,     // write data
    input wire logic [7:0]      REG_RDATA_OUT,    // read data
    input wire logic            CONFIG_READY_OUT, // loaded
    input wire logic            AUX3_ENABLE_OUT,  // enable
    input wire logic            RAIL6_PRESET_OUT, // preset
    input wire logic            RAIL6_PRESET_2V4_OUT, // 2.4 V
    input wire logic            SWB2_ENABLE_OUT,  // b2 enable
    input wire logic            REG1_ENABLE_OUT   // reg 1 enable
);
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RSTN_IN);

    logic       loaded_reg;
    logic [7:0] mask_reg;
    logic [7:0] src_reg;
    logic [7:0] tim_reg;
    logic [7:0] sel_val;

    // shadow of the registers, rebuilt from the port traffic
    always_ff @(posedge CLOCK_IN)
    begin
        if (!RSTN_IN)
        begin
            loaded_reg <= 1'b0;
            mask_reg <= 8'h00;
            src_reg <= 8'h00;
            tim_reg <= 8'h00;
        end
        else if (!loaded_reg)
        begin
            loaded_reg <= 1'b1;
            mask_reg <= OTP_MASK_A_IN;
            src_reg <= OTP_SOURCE_IN;
            tim_reg <= OTP_TIMING_IN;
        end
        else if (REG_WR_IN)
        begin
            case (REG_ADDR_IN)
                8'h1f:   mask_reg <= REG_WDATA_IN;
                8'h20:   src_reg <= REG_WDATA_IN;
                8'h21:   tim_reg <= REG_WDATA_IN;
                default: ;
            endcase
        end
    end

    // shadow value at the presented address
    always_comb
    begin
        case (REG_ADDR_IN)
            8'h1f:   sel_val = mask_reg;
            8'h20:   sel_val = src_reg;
            8'h21:   sel_val = tim_reg;
            default: sel_val = 8'h00;
        endcase
    end

    chk_read_mux: assert property (
        1'b1 |=> REG_RDATA_OUT == $past(sel_val))
        else $error("read data differs from register");
    chk_ready_load: assert property (
        $rose(RSTN_IN) |-> !CONFIG_READY_OUT ##1 !CONFIG_READY_OUT
            ##1 CONFIG_READY_OUT)
        else $error("ready not on second edge");
    chk_ready_holds: assert property (
        CONFIG_READY_OUT |=> CONFIG_READY_OUT)
        else $error("ready dropped");
    chk_quiet_unloaded: assert property (
        !CONFIG_READY_OUT |-> !(AUX3_ENABLE_OUT || RAIL6_PRESET_OUT
            || SWB2_ENABLE_OUT || REG1_ENABLE_OUT))
        else $error("output active before load");
    chk_preset_option: assert property (
        !src_reg[7] |=> !RAIL6_PRESET_OUT)
        else $error("preset without option");
    chk_sleep_wins: assert property (
        CONTROL_PINS_IN.sleep [*8] |-> !RAIL6_PRESET_OUT)
        else $error("preset during sleep");
    chk_preset_step: assert property (
        RAIL6_PRESET_2V4_OUT
        == (RAIL6_PRESET_OUT && $past(RAIL6_STEP_25MV_IN)))
        else $error("2.4 V flag not preset with step");
    chk_combine_route: assert property (
        CONFIG_READY_OUT && tim_reg[7]
        |=> SWB2_ENABLE_OUT == $past(LOAD_SWITCH_B_FIRST_LOGIC_IN))
        else $error("combine routing wrong");
    chk_swap_route: assert property (
        CONFIG_READY_OUT && tim_reg[6]
        |=> REG1_ENABLE_OUT == $past(SWB2_LOGIC_IN) && ($past(tim_reg[7])
            || SWB2_ENABLE_OUT == $past(REG1_LOGIC_IN)))
        else $error("swap routing wrong");
    chk_plain_route: assert property (
        CONFIG_READY_OUT && tim_reg[7:6] == 2'b00
        |=> REG1_ENABLE_OUT == $past(REG1_LOGIC_IN)
            && SWB2_ENABLE_OUT == $past(SWB2_LOGIC_IN))
        else $error("normal routing wrong");
    chk_always_on: assert property (
        (CONFIG_READY_OUT && src_reg[4:0] == 5'h1f && mask_reg == 8'hff
            && tim_reg[2:0] == 3'h0) [*8] |-> AUX3_ENABLE_OUT)
        else $error("constant source not enabling");
endmodule // aux_rail3_enable_logic_asserts

bind aux_rail3_enable_logic aux_rail3_enable_logic_asserts chk_u (
    .CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN),
    .CONTROL_PINS_IN(CONTROL_PINS_IN), .LOAD_SWITCH_B_FIRST_LOGIC_IN(LOAD_SWITCH_B_FIRST_LOGIC_IN),
    .SWB2_LOGIC_IN(SWB2_LOGIC_IN), .REG1_LOGIC_IN(REG1_LOGIC_IN),
    .RAIL6_STEP_25MV_IN(RAIL6_STEP_25MV_IN),
    .OTP_MASK_A_IN(OTP_MASK_A_IN), .OTP_SOURCE_IN(OTP_SOURCE_IN),
    .OTP_TIMING_IN(OTP_TIMING_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WR_IN(REG_WR_IN), .REG_WDATA_IN(REG_WDATA_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .CONFIG_READY_OUT(CONFIG_READY_OUT),
    .AUX3_ENABLE_OUT(AUX3_ENABLE_OUT), .RAIL6_PRESET_OUT(RAIL6_PRESET_OUT),
    .RAIL6_PRESET_2V4_OUT(RAIL6_PRESET_2V4_OUT),
    .SWB2_ENABLE_OUT(SWB2_ENABLE_OUT), .REG1_ENABLE_OUT(REG1_ENABLE_OUT)
);

// ---- verification/aux_rail3_enable_logic_tb.sv ----
`timescale 1ns/1ns
module aux_rail3_enable_logic_tb;
    localparam int TICKS = 4;
    localparam logic [7:0] OTP_A = 8'hff;
    localparam logic [7:0] OTP_S = 8'h7f;
    localparam logic [7:0] OTP_T = 8'hc0;
    logic clk, rstn, step, wr, ready, en, pre, pre24, swb2_en, reg1_en;
    logic [7:0] addr, wdata, rdata;
    logic [2:0] rails;
    aux3_pkg::power_good_s good;
    aux3_pkg::pins_s pins;
    int err_total, num_checks;

    rail_partner partner_u (
        .clk_in(clk), .good_out(good), .pins_out(pins), .logic_out(rails)
    );
    aux_rail3_enable_logic #(.TICK_CYCLES(TICKS)) dut_u (
        .CLOCK_IN(clk), .RSTN_IN(rstn), .POWER_GOOD_IN(good),
        .CONTROL_PINS_IN(pins), .RAIL6_STEP_25MV_IN(step),
        .LOAD_SWITCH_B_FIRST_LOGIC_IN(rails[2]), .SWB2_LOGIC_IN(rails[1]),
        .REG1_LOGIC_IN(rails[0]), .OTP_MASK_A_IN(OTP_A),
        .OTP_SOURCE_IN(OTP_S), .OTP_TIMING_IN(OTP_T), .REG_ADDR_IN(addr),
        .REG_WR_IN(wr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
        .CONFIG_READY_OUT(ready), .AUX3_ENABLE_OUT(en),
        .RAIL6_PRESET_OUT(pre), .RAIL6_PRESET_2V4_OUT(pre24),
        .SWB2_ENABLE_OUT(swb2_en), .REG1_ENABLE_OUT(reg1_en)
    );

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // shared helpers: compare, verdict, waits, register cycles
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d compares %0d", err_total, num_checks);
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_en(input logic want, input int lim, output int n);
        n = 0;
        while (en !== want)
        begin
            @(posedge clk);
            #1 n++;
            if (n > lim)
            begin
                err_total++;
                stop_test();
            end
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
        @(posedge clk);
        addr <= a;
        cyc(2);
        #1 check(rdata, want);
    endtask
    function automatic logic src_hit(input logic [2:0] c,
                                     input logic [5:0] p);
        case (c)
            3'h0: return p[0];
            3'h1: return p[1];
            3'h2: return p[4];
            3'h3: return p[3];
            3'h4: return p[2];
            3'h5: return p[2] & p[3];
            3'h6: return p[5];
            default: return 1'b1;
        endcase
    endfunction

    // reset, quiet outputs, then defaults from stored memory
    task automatic t_reset();
        int n;
        @(posedge clk);
        rstn <= 1'b0;
        cyc(5);
        #1 check({ready, en, pre, swb2_en, reg1_en}, 5'h00);
        @(posedge clk);
        rstn <= 1'b1;
        cyc(3);
        #1 check(ready, 1'b1);
        rd_chk(8'h1f, OTP_A);
        rd_chk(8'h20, OTP_S);
        rd_chk(8'h21, OTP_T);
        wait_en(1'b1, 20, n);
    endtask

    // write, read back, unmapped offset
    task automatic t_regs();
        logic [7:0] v [3];
        v = '{8'ha5, 8'h6d, 8'h3c};
        for (int i = 0; i < 3; i++)
            wr_reg(8'(8'h1f + i), v[i]);
        wr_reg(8'h22, 8'hff);
        for (int i = 0; i < 3; i++)
            rd_chk(8'(8'h1f + i), v[i]);
        rd_chk(8'h22, 8'h00);
    endtask

    // every source code against single pins and the 3-and-4 pair
    task automatic t_source();
        logic [5:0] pat [8];
        pat = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h0c};
        wr_reg(8'h1f, 8'hff);
        wr_reg(8'h21, 8'h00);
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(8'h20, {3'b000, 3'(c), 2'b11});
            for (int p = 0; p < 8; p++)
            begin
                partner_u.set_pins({1'b0, pat[p]});
                cyc(12);
                #1 check(en, src_hit(3'(c), pat[p]));
            end
        end
    endtask

    // one rail not good: blocks unless masked
    task automatic t_masks();
        logic [9:0] m;
        partner_u.set_pins('0);
        for (int i = 0; i < 10; i++)
        begin
            m = ~(10'h001 << i);
            wr_reg(8'h1f, m[9:2]);
            wr_reg(8'h20, {6'b000111, m[1:0]});
            partner_u.set_good(m);
            cyc(12);
            #1 check(en, 1'b0);
            wr_reg(8'h1f, 8'hff);
            wr_reg(8'h20, 8'h1f);
            cyc(12);
            #1 check(en, 1'b1);
            partner_u.set_good('1);
        end
    endtask

    // rise codes then fall codes, latency past the zero-delay base
    task automatic t_delays();
        int ms [8];
        int base, n, want;
        ms = '{0, 2, 4, 8, 16, 24, 32, 64};
        wr_reg(8'h20, 8'h1e);
        for (int k = 0; k < 16; k++)
        begin
            wr_reg(8'h21, k[3] ? {2'b00, 3'(k), 3'b000} : 8'(k[2:0]));
            partner_u.set_good(k[3] ? 10'h3ff : 10'h3fe);
            wait_en(k[3], 400, n);
            partner_u.set_good(k[3] ? 10'h3fe : 10'h3ff);
            wait_en(!k[3], 400, n);
            if (k[2:0] == 3'h0)
                base = n;
            want = base + ms[k[2:0]] * TICKS;
            check(n >= want && n <= want + TICKS, 1'b1);
        end
        wr_reg(8'h21, 8'h01);
        partner_u.set_good(10'h3ff);
        cyc(4);
        partner_u.set_good(10'h3fe);
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clk);
            #1 check(en, 1'b0);
        end
    endtask

    // option, sleep, step and control 2 in all combinations
    task automatic t_preset();
        logic [3:0] v;
        for (int i = 0; i < 16; i++)
        begin
            v = 4'(i);
            wr_reg(8'h20, {v[3], 7'h1f});
            partner_u.set_pins({v[2], 4'h0, v[0], 1'b0});
            step <= v[1];
            cyc(8);
            #1 check(pre, v[3] & v[0] & ~v[2]);
            check(pre24, v[3] & v[0] & ~v[2] & v[1]);
        end
    endtask

    // combine and swap against every rail logic pattern
    task automatic t_route();
        logic [4:0] v;
        for (int i = 0; i < 32; i++)
        begin
            v = 5'(i);
            wr_reg(8'h21, {v[4:3], 6'h00});
            partner_u.set_logic(v[2:0]);
            cyc(3);
            #1 check(reg1_en, v[3] ? v[1] : v[0]);
            check(swb2_en, v[4] ? v[2] : (v[3] ? v[0] : v[1]));
        end
    endtask

    // main sequence, with a second reset at the end
    initial
    begin
        err_total = 0;
        num_checks = 0;
        rstn = 1'b0;
        step = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        t_reset();
        t_regs();
        t_source();
        t_masks();
        t_delays();
        t_preset();
        t_route();
        t_reset();
        stop_test();
    end
endmodule // aux_rail3_enable_logic_tb
